// >>> gcc_pkg.sv
package gcc_pkg;
   localparam int NUM_GEN = 6;
   localparam int NUM_PCLK = 8;
   localparam int NUM_SRC = 6;
   localparam int DIV_W = 16;
   localparam int CNT_W = 18;
   // register indices; byte address is four times the index
   localparam logic [5:0] REG_CTRL_IDX = 6'h00;
   localparam logic [5:0] REG_STATUS_IDX = 6'h01;
   localparam logic [5:0] REG_PCLK_CTRL_IDX = 6'h02;
   localparam logic [5:0] REG_GEN_CTRL_IDX = 6'h04;
   localparam logic [5:0] REG_GEN_DIV_IDX = 6'h08;
   // access sizes on wr_size_in
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   // field positions
   localparam int CTRL_SOFT_RESET_BIT = 0;
   localparam int STATUS_SYNC_PENDING_BIT = 7;
   localparam int PC_INDEX_LSB = 0;
   localparam int PC_PICK_LSB = 8;
   localparam int PC_ON_BIT = 14;
   localparam int PC_FREEZE_BIT = 15;
   localparam int GC_INDEX_LSB = 0;
   localparam int GC_SRC_LSB = 8;
   localparam int GC_EN_BIT = 16;
   localparam int GC_DUTY_BIT = 17;
   localparam int GC_IDLE_BIT = 18;
   localparam int GC_OE_BIT = 19;
   localparam int GC_MODE_BIT = 20;
   localparam int GC_STBY_BIT = 21;
   localparam int GD_INDEX_LSB = 0;
   localparam int GD_DIV_LSB = 8;
   // source codes: 0..5 oscillators, pad input, producer 1 output
   localparam logic [4:0] SRC_PAD = 5'h06;
   localparam logic [4:0] SRC_PROD1 = 5'h07;
   localparam logic [4:0] GEN0_SRC_RST = 5'h00;
   localparam logic [3:0] MAX_EXP = 4'hF;
   localparam logic [1:0] SYNC_CYCLES = 2'h3;
   typedef enum logic [1:0] {OP_CTRL, OP_PCLK, OP_GCTRL, OP_GDIV} gcc_op_t;
   typedef struct packed {
      logic en;
      logic [4:0] src;
      logic duty;
      logic idle;
      logic oe;
      logic mode;
      logic stby;
      logic [DIV_W-1:0] div;
      logic [4:0] eff_src;
      logic prev;
      logic [CNT_W-1:0] cnt;
      logic clk;
   } gcc_gen_t;
   typedef struct packed {
      logic [3:0] pick;
      logic on;
      logic freeze;
   } gcc_pclk_t;
   typedef struct packed {
      logic v;
      logic [1:0] cnt;
      gcc_op_t kind;
      logic [5:0] idx;
      logic [31:0] data;
   } gcc_op_slot_t;
   localparam gcc_gen_t GEN_RST = '0;
   localparam gcc_gen_t GEN0_RST = '{en: 1'b1, src: GEN0_SRC_RST, eff_src: GEN0_SRC_RST, default: '0};
   localparam gcc_pclk_t PCLK_RST = '0;
endpackage

// >>> gcc_top.sv
// Operation
// R1 - soft reset restores all except frozen channels
// R2 - eight sources; producer 1 cannot self-select
// R3 - pad x feeds or outputs producer x
// R4 - producer 0 drives main system clock
// R5 - enable bit starts; cleared output gated
// R6 - keep old source until new ready
// R7 - prescale factor read per prescale mode
// R8 - mode0 divide by factor; mode1 power-of-two
// R9 - duty balance gives 50/50 odd division
// R10 - pad output and enable drive pad
// R11 - pad idle level when output off
// R12 - standby freezes pad unless keep-in-standby
// R13 - enable write synchronized; old reads meanwhile
// R14 - clearing enable gates; pending clears after
// R15 - software disables before changing producer pick
// R16 - frozen peripheral control ignores later writes
// R17 - freeze also locks its producer registers
// R18 - producer 0 never frozen, always reset
// R19 - byte write of index selects read channel
// R20 - sleep request wakes producer and delivers
// R21 - synchronized operation sets pending until done
// R22 - operation during pending stalls, still completes
// R23 - producer control, prescale, control writes synchronize
// R24 - soft reset reads one until done
// R25 - peripheral control written as one half-word
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module gcc_top
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // register port
   input wire logic [5:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic [1:0] wr_size_in,
   input wire logic wr_stb_in,
   input wire logic rd_stb_in,
   output logic [31:0] rd_data_out,
   output logic bus_stall_out,
   // clock sources
   input wire logic [gcc_pkg::NUM_SRC-1:0] src_clk_in,
   input wire logic [gcc_pkg::NUM_SRC-1:0] src_ready_in,
   output logic [gcc_pkg::NUM_SRC-1:0] src_req_out,
   // clock pads
   input wire logic [gcc_pkg::NUM_GEN-1:0] pad_in,
   output logic [gcc_pkg::NUM_GEN-1:0] pad_out,
   output logic [gcc_pkg::NUM_GEN-1:0] pad_oe_out,
   // power state
   input wire logic standby_in,
   input wire logic sleep_in,
   input wire logic [gcc_pkg::NUM_PCLK-1:0] pclk_req_in,
   // produced clocks
   output logic main_clk_out,
   output logic [gcc_pkg::NUM_PCLK-1:0] pclk_out
);
   import gcc_pkg::*;

   typedef struct packed {
      gcc_gen_t [NUM_GEN-1:0] gen;
      gcc_pclk_t [NUM_PCLK-1:0] pc;
      logic [3:0] gen_idx;
      logic [3:0] div_idx;
      logic [5:0] pc_idx;
      gcc_op_slot_t pend;
      gcc_op_slot_t hold;
      logic [31:0] rd_data;
      logic [NUM_SRC-1:0] src_req;
      logic [NUM_GEN-1:0] pad_o;
      logic [NUM_GEN-1:0] pad_oe;
      logic main_clk;
      logic [NUM_PCLK-1:0] pclk;
   } gcc_state_t;

   gcc_state_t s_q;
   gcc_state_t s_d;

   function automatic logic src_level(input logic [4:0] code, input int g, input gcc_state_t s);
      logic lv;
      lv = 1'b0;
      if (code < 5'(NUM_SRC))
         lv = src_clk_in[code[2:0]];
      else if (code == SRC_PAD)
         lv = pad_in[g];
      else if (code == SRC_PROD1)
         lv = s.gen[1].clk;
      return lv;
   endfunction

   function automatic logic src_ready(input logic [4:0] code);
      logic r;
      r = 1'b1;
      if (code < 5'(NUM_SRC))
         r = src_ready_in[code[2:0]];
      return r;
   endfunction

   // division factor in source periods
   function automatic logic [16:0] div_factor(input logic mode, input logic [DIV_W-1:0] div);
      logic [3:0] e;
      logic [16:0] n;
      e = (div > 16'(MAX_EXP)) ? MAX_EXP : div[3:0];
      if (mode)
         n = 17'h00002 << e; // [R8]
      else if (div <= 16'h0001)
         n = 17'h00001; // [R8]
      else
         n = {1'b0, div}; // [R8]
      return n;
   endfunction

   logic [NUM_GEN-1:0] gen_frozen;
   logic [NUM_GEN-1:0] wake;

   always_comb
   begin
      gcc_op_slot_t op;
      logic [16:0] n;
      logic [CNT_W-1:0] hi;
      logic [CNT_W-1:0] top;
      logic lv;
      logic run;
      logic stop;
      logic [4:0] new_src;
      s_d = s_q;
      op = '0;
      n = '0;
      hi = '0;
      top = '0;
      lv = 1'b0;
      run = 1'b0;
      stop = 1'b0;
      new_src = '0;
      gen_frozen = '0;
      wake = '0;
      for (int c = 0; c < NUM_PCLK; c++)
      begin
         for (int g = 1; g < NUM_GEN; g++)
         begin
            if (s_q.pc[c].freeze && s_q.pc[c].pick == 4'(g))
               gen_frozen[g] = 1'b1; // [R17] [R18]
         end
         for (int g = 0; g < NUM_GEN; g++)
         begin
            if (sleep_in && pclk_req_in[c] && !s_q.pc[c].on && s_q.pc[c].pick == 4'(g))
               wake[g] = 1'b1; // [R20]
         end
      end

      // synchronisation of a pending write
      if (s_q.pend.v)
      begin
         if (s_q.pend.cnt == SYNC_CYCLES - 2'h1)
         begin
            op = s_q.pend;
            s_d.pend = s_q.hold; // [R22]
            s_d.pend.cnt = 2'h0;
            s_d.hold = '0;
            case (op.kind)
               OP_CTRL:
               begin
                  for (int g = 0; g < NUM_GEN; g++)
                  begin
                     if (g == 0)
                        s_d.gen[g] = GEN0_RST; // [R18]
                     else if (!gen_frozen[g])
                        s_d.gen[g] = GEN_RST; // [R1]
                  end
                  for (int c = 0; c < NUM_PCLK; c++)
                  begin
                     if (!s_q.pc[c].freeze)
                        s_d.pc[c] = PCLK_RST; // [R1] [R16]
                  end
                  s_d.gen_idx = '0;
                  s_d.div_idx = '0;
                  s_d.pc_idx = '0;
               end
               OP_PCLK:
               begin
                  if (op.idx < 6'(NUM_PCLK) && !s_q.pc[op.idx[2:0]].freeze) // [R16]
                  begin
                     s_d.pc[op.idx[2:0]].pick = op.data[PC_PICK_LSB +: 4];
                     s_d.pc[op.idx[2:0]].on = op.data[PC_ON_BIT]; // [R13] [R14]
                     s_d.pc[op.idx[2:0]].freeze = op.data[PC_FREEZE_BIT];
                  end
               end
               OP_GCTRL:
               begin
                  if (op.idx < 6'(NUM_GEN) && !gen_frozen[op.idx[2:0]]) // [R17]
                  begin
                     new_src = op.data[GC_SRC_LSB +: 5];
                     if (op.idx == 6'h01 && new_src == SRC_PROD1)
                        new_src = s_q.gen[1].src; // [R2]
                     s_d.gen[op.idx[2:0]].src = new_src;
                     s_d.gen[op.idx[2:0]].en = op.data[GC_EN_BIT]; // [R5]
                     s_d.gen[op.idx[2:0]].duty = op.data[GC_DUTY_BIT];
                     s_d.gen[op.idx[2:0]].idle = op.data[GC_IDLE_BIT];
                     s_d.gen[op.idx[2:0]].oe = op.data[GC_OE_BIT];
                     s_d.gen[op.idx[2:0]].mode = op.data[GC_MODE_BIT];
                     s_d.gen[op.idx[2:0]].stby = op.data[GC_STBY_BIT];
                  end
               end
               default:
               begin
                  if (op.idx < 6'(NUM_GEN) && !gen_frozen[op.idx[2:0]]) // [R17]
                     s_d.gen[op.idx[2:0]].div = op.data[GD_DIV_LSB +: DIV_W];
               end
            endcase
         end
         else
            s_d.pend.cnt = s_q.pend.cnt + 2'h1;
      end

      // register writes
      if (wr_stb_in)
      begin
         op = '0;
         op.v = 1'b1;
         op.data = wr_data_in;
         case (addr_in)
            {REG_CTRL_IDX[3:0], 2'b00}:
            begin
               op.kind = OP_CTRL;
               op.v = wr_data_in[CTRL_SOFT_RESET_BIT]; // writing zero has no effect
            end
            {REG_PCLK_CTRL_IDX[3:0], 2'b00}:
            begin
               op.kind = OP_PCLK;
               op.idx = wr_data_in[PC_INDEX_LSB +: 6];
               s_d.pc_idx = op.idx; // [R19]
               op.v = (wr_size_in != SIZE_BYTE); // [R25]
            end
            {REG_GEN_CTRL_IDX[3:0], 2'b00}:
            begin
               op.kind = OP_GCTRL;
               op.idx = {2'b00, wr_data_in[GC_INDEX_LSB +: 4]};
               s_d.gen_idx = op.idx[3:0]; // [R19]
               op.v = (wr_size_in == SIZE_WORD);
            end
            {REG_GEN_DIV_IDX[3:0], 2'b00}:
            begin
               op.kind = OP_GDIV;
               op.idx = {2'b00, wr_data_in[GD_INDEX_LSB +: 4]};
               s_d.div_idx = op.idx[3:0]; // [R19]
               op.v = (wr_size_in == SIZE_WORD);
            end
            default:
               op.v = 1'b0;
         endcase
         if (op.v)
         begin
            if (!s_d.pend.v)
               s_d.pend = op; // [R21] [R23]
            else if (!s_d.hold.v)
               s_d.hold = op; // [R22]
         end
      end

      // register reads, data in the next cycle
      s_d.rd_data = '0;
      if (rd_stb_in)
      begin
         case (addr_in)
            {REG_CTRL_IDX[3:0], 2'b00}:
               s_d.rd_data[CTRL_SOFT_RESET_BIT] = (s_q.pend.v && s_q.pend.kind == OP_CTRL)
                  || (s_q.hold.v && s_q.hold.kind == OP_CTRL); // [R24]
            {REG_STATUS_IDX[3:0], 2'b00}:
               s_d.rd_data[STATUS_SYNC_PENDING_BIT] = s_q.pend.v; // [R21] [R24]
            {REG_PCLK_CTRL_IDX[3:0], 2'b00}:
            begin
               s_d.rd_data[PC_INDEX_LSB +: 6] = s_q.pc_idx;
               if (s_q.pc_idx < 6'(NUM_PCLK))
               begin
                  s_d.rd_data[PC_PICK_LSB +: 4] = s_q.pc[s_q.pc_idx[2:0]].pick;
                  s_d.rd_data[PC_ON_BIT] = s_q.pc[s_q.pc_idx[2:0]].on; // [R13]
                  s_d.rd_data[PC_FREEZE_BIT] = s_q.pc[s_q.pc_idx[2:0]].freeze;
               end
            end
            {REG_GEN_CTRL_IDX[3:0], 2'b00}:
            begin
               s_d.rd_data[GC_INDEX_LSB +: 4] = s_q.gen_idx;
               if (s_q.gen_idx < 4'(NUM_GEN))
               begin
                  s_d.rd_data[GC_SRC_LSB +: 5] = s_q.gen[s_q.gen_idx[2:0]].src;
                  s_d.rd_data[GC_EN_BIT] = s_q.gen[s_q.gen_idx[2:0]].en;
                  s_d.rd_data[GC_DUTY_BIT] = s_q.gen[s_q.gen_idx[2:0]].duty;
                  s_d.rd_data[GC_IDLE_BIT] = s_q.gen[s_q.gen_idx[2:0]].idle;
                  s_d.rd_data[GC_OE_BIT] = s_q.gen[s_q.gen_idx[2:0]].oe;
                  s_d.rd_data[GC_MODE_BIT] = s_q.gen[s_q.gen_idx[2:0]].mode;
                  s_d.rd_data[GC_STBY_BIT] = s_q.gen[s_q.gen_idx[2:0]].stby;
               end
            end
            {REG_GEN_DIV_IDX[3:0], 2'b00}:
            begin
               s_d.rd_data[GD_INDEX_LSB +: 4] = s_q.div_idx;
               if (s_q.div_idx < 4'(NUM_GEN))
                  s_d.rd_data[GD_DIV_LSB +: DIV_W] = s_q.gen[s_q.div_idx[2:0]].div;
            end
            default:
               s_d.rd_data = '0;
         endcase
      end

      // clock producers
      s_d.src_req = '0;
      for (int g = 0; g < NUM_GEN; g++)
      begin
         run = s_q.gen[g].en || wake[g]; // [R5] [R20]
         stop = standby_in && !s_q.gen[g].stby && !wake[g]; // [R12]
         if (run || (s_q.gen[g].en && s_q.gen[g].oe))
         begin
            if (s_q.gen[g].eff_src < 5'(NUM_SRC))
               s_d.src_req[s_q.gen[g].eff_src[2:0]] = 1'b1; // [R6] [R10]
            if (s_q.gen[g].src < 5'(NUM_SRC))
               s_d.src_req[s_q.gen[g].src[2:0]] = 1'b1; // [R6]
         end
         lv = src_level(s_q.gen[g].eff_src, g, s_q);
         s_d.gen[g].prev = lv;
         n = div_factor(s_q.gen[g].mode, s_q.gen[g].div); // [R7]
         top = {n, 1'b0} - 18'h00001;
         if (s_q.gen[g].duty || !n[0] || n == 17'h00001)
            hi = {1'b0, n}; // [R9]
         else
            hi = {1'b0, n} + 18'h00001;
         if (s_q.gen[g].eff_src != s_q.gen[g].src && src_ready(s_q.gen[g].src) && !s_q.gen[g].clk)
         begin
            s_d.gen[g].eff_src = s_q.gen[g].src; // [R6]
            s_d.gen[g].prev = src_level(s_q.gen[g].src, g, s_q);
            s_d.gen[g].cnt = '0;
         end
         else if (!run)
         begin
            s_d.gen[g].cnt = '0;
            s_d.gen[g].clk = 1'b0; // [R5]
         end
         else if (!stop && lv != s_q.gen[g].prev)
         begin
            s_d.gen[g].cnt = (s_q.gen[g].cnt >= top) ? '0 : s_q.gen[g].cnt + 18'h00001;
            s_d.gen[g].clk = (s_d.gen[g].cnt < hi); // [R8] [R9]
         end
         s_d.pad_oe[g] = s_q.gen[g].oe && s_q.gen[g].src != SRC_PAD; // [R3]
         if (s_q.gen[g].oe && s_q.gen[g].en && !stop)
            s_d.pad_o[g] = s_d.gen[g].clk; // [R10]
         else
            s_d.pad_o[g] = s_q.gen[g].idle; // [R11] [R12]
      end
      s_d.main_clk = s_d.gen[0].clk; // [R4]

      // peripheral clock gates
      for (int c = 0; c < NUM_PCLK; c++)
      begin
         s_d.pclk[c] = 1'b0;
         if ((s_q.pc[c].on || (sleep_in && pclk_req_in[c])) && s_q.pc[c].pick < 4'(NUM_GEN))
            s_d.pclk[c] = s_d.gen[s_q.pc[c].pick[2:0]].clk; // [R14] [R20]
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s_q <= '0;
         s_q.gen[0] <= GEN0_RST; // [R18]
      end
      else if (clk_en_in)
         s_q <= s_d;
   end

   assign rd_data_out = s_q.rd_data;
   assign bus_stall_out = s_q.hold.v;
   assign src_req_out = s_q.src_req;
   assign pad_out = s_q.pad_o;
   assign pad_oe_out = s_q.pad_oe;
   assign main_clk_out = s_q.main_clk;
   assign pclk_out = s_q.pclk;
endmodule

// >>> gcc_top_assertions.sv
`timescale 1ns/10ps
module gcc_top_checker
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [5:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic [1:0] wr_size_in,
   input wire logic wr_stb_in,
   input wire logic rd_stb_in,
   input wire logic [31:0] rd_data_out,
   input wire logic bus_stall_out,
   // clocks
   input wire logic [gcc_pkg::NUM_SRC-1:0] src_req_out,
   input wire logic main_clk_out
);
   import gcc_pkg::*;
   logic [2:0] quiet_q;
   // cycles since the last write, saturating
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         quiet_q <= 3'h7;
      else if (wr_stb_in)
         quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
         quiet_q <= quiet_q + 3'h1;
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence s_sync_wr;
      wr_stb_in && quiet_q == 3'h7 && wr_size_in == SIZE_WORD && addr_in inside {6'h10, 6'h20};
   endsequence
   sequence s_srst_wr;
      wr_stb_in && quiet_q == 3'h7 && addr_in == 6'h00 && wr_data_in[CTRL_SOFT_RESET_BIT];
   endsequence
   sequence s_quiet4;
      !wr_stb_in [*3] ##1 !wr_stb_in && rd_stb_in;
   endsequence
   a_rd_idle_zero: assert property (!$past(rd_stb_in) |-> rd_data_out == '0)
      else $error("read data present without a read");
   a_sync_flag_set: assert property (s_sync_wr ##1 rd_stb_in && addr_in == 6'h04 |=> rd_data_out[7])
      else $error("pending flag not set after write");
   a_sync_flag_clr: assert property (s_sync_wr ##1 s_quiet4 ##0 addr_in == 6'h04 |=> !rd_data_out[7])
      else $error("pending flag not cleared");
   a_srst_reads_one: assert property (s_srst_wr ##1 rd_stb_in && addr_in == 6'h00 |=> rd_data_out[0])
      else $error("soft reset bit not busy");
   a_srst_done: assert property (s_srst_wr ##1 s_quiet4 ##0 addr_in == 6'h00 |=> !rd_data_out[0])
      else $error("soft reset bit stuck");
   a_stall_cause: assert property ($rose(bus_stall_out) |-> $past(wr_stb_in))
      else $error("stall without a write");
   a_stall_bounded: assert property (bus_stall_out |-> ##[1:8] !bus_stall_out)
      else $error("stall never released");
   a_main_boot: assert property ($rose(rst_n_in) |-> ##[0:2] src_req_out[0] ##[1:60] $changed(main_clk_out))
      else $error("main clock not running after reset");
endmodule

bind gcc_top gcc_top_checker i_chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
   .wr_data_in(wr_data_in), .wr_size_in(wr_size_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
   .rd_data_out(rd_data_out), .bus_stall_out(bus_stall_out), .src_req_out(src_req_out),
   .main_clk_out(main_clk_out));

// >>> gcc_osc_model.sv
`timescale 1ns/10ps
module gcc_osc_model
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // source handshake
   input wire logic [gcc_pkg::NUM_SRC-1:0] src_req_in,
   output logic [gcc_pkg::NUM_SRC-1:0] src_clk_out,
   output logic [gcc_pkg::NUM_SRC-1:0] src_ready_out
);
   import gcc_pkg::*;
   int cnt [NUM_SRC];
   // later sources start slower; a stopped oscillator holds its level
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         src_clk_out <= '0;
         src_ready_out <= '0;
         for (int s = 0; s < NUM_SRC; s++)
            cnt[s] <= 0;
      end
      else
         for (int s = 0; s < NUM_SRC; s++)
         begin
            cnt[s] <= src_req_in[s] ? cnt[s] + 1 : 0;
            src_ready_out[s] <= src_req_in[s] && cnt[s] >= 4 + 8 * s;
            if (src_ready_out[s] && cnt[s][0])
               src_clk_out[s] <= !src_clk_out[s];
         end
   end
endmodule

// >>> gcc_tb_top.sv
`timescale 1ns/10ps
module gcc_tb_top;
   import gcc_pkg::*;
   localparam int EN = 1, DU = 2, IDL = 4, OE = 8, MD = 16, SB = 32;
   logic clk, rst_n, wstb, rstb, stby, slp, stall, mclk;
   logic rd_seen = 1'b0;
   logic [5:0] addr;
   logic [1:0] wsz;
   logic [31:0] wdat, rdat;
   logic [31:0] exp_q[$];
   logic [NUM_SRC-1:0] sclk, srdy, sreq;
   logic [NUM_GEN-1:0] pin, pad, poe;
   logic [NUM_PCLK-1:0] preq, pclk;
   int err_count = 0;
   int compares = 0;
   int dv[4] = '{0, 3, 1, 5};
   int fl[4] = '{DU, DU, MD, DU};
   int nn[4] = '{1, 3, 4, 5};
   gcc_top i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1), .addr_in(addr), .wr_data_in(wdat),
      .wr_size_in(wsz), .wr_stb_in(wstb), .rd_stb_in(rstb), .rd_data_out(rdat), .bus_stall_out(stall),
      .src_clk_in(sclk), .src_ready_in(srdy), .src_req_out(sreq), .pad_in(pin), .pad_out(pad),
      .pad_oe_out(poe), .standby_in(stby), .sleep_in(slp), .pclk_req_in(preq), .main_clk_out(mclk),
      .pclk_out(pclk));
   gcc_osc_model i_osc (.clk_sys_in(clk), .rst_n_in(rst_n), .src_req_in(sreq), .src_clk_out(sclk),
      .src_ready_out(srdy));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] gc(int i, int s, int f);
      return 32'(i) | 32'(s << GC_SRC_LSB) | 32'(f << GC_EN_BIT);
   endfunction
   function automatic logic [31:0] pc(int i, int p, int f);
      return 32'(i) | 32'(p << PC_PICK_LSB) | 32'(f << PC_ON_BIT);
   endfunction
   function automatic logic [31:0] gd(int i, int d);
      return 32'(i) | 32'(d << GD_DIV_LSB);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wrap_up;
      if (err_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic gap(input int n);
      wstb <= 1'b0;
      rstb <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] z = SIZE_WORD);
      addr <= a;
      wdat <= d;
      wsz <= (a == 6'h08 && z == SIZE_WORD) ? SIZE_HALF : z;
      rstb <= 1'b0;
      wstb <= 1'b1;
      @(posedge clk);
   endtask
   // the expectation is queued, masked, when the read is issued
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
      exp_q.push_back(e & m);
      exp_q.push_back(m);
      addr <= a;
      wstb <= 1'b0;
      rstb <= 1'b1;
      @(posedge clk);
   endtask
   task automatic rdg(input logic [5:0] a, input int i, input logic [31:0] e);
      wr(a, 32'(i), SIZE_BYTE);
      gap(4);
      rd(a, e);
      gap(1);
   endtask
   // w below 8 picks a peripheral clock, else pad w-8
   task automatic tog(input int w, output int c);
      logic lv, nv;
      c = 0;
      lv = w < 8 ? pclk[w] : pad[w-8];
      repeat (40)
      begin
         @(posedge clk);
         nv = w < 8 ? pclk[w] : pad[w-8];
         c += int'(nv !== lv);
         lv = nv;
      end
   endtask
   // source half-period is two system cycles
   task automatic per(input int g, input int n);
      int h, l;
      logic lv;
      h = 0;
      l = 0;
      lv = pad[g];
      for (int k = 0; k < 300; k++)
      begin
         @(posedge clk);
         if (pad[g] && !lv)
            break;
         lv = pad[g];
      end
      while (pad[g] === 1'b1 && h < 300)
      begin
         @(posedge clk);
         h++;
      end
      while (pad[g] === 1'b0 && l < 300)
      begin
         @(posedge clk);
         l++;
      end
      chk("pad_high", 2 * n, h);
      chk("pad_low", 2 * n, l);
   endtask
   // pop expectation then mask in a fixed order
   always @(posedge clk)
   begin
      logic [31:0] ev;
      logic [31:0] mv;
      ev = '0;
      mv = '0;
      if (rd_seen)
      begin
         ev = exp_q.pop_front();
         mv = exp_q.pop_front();
         chk("rd_data_out", ev, rdat & mv);
      end
      rd_seen <= rstb;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      wrap_up();
   end
   initial
   begin
      int c, iv;
      addr = '0;
      wdat = '0;
      wsz = '0;
      wstb = 1'b0;
      rstb = 1'b0;
      stby = 1'b0;
      slp = 1'b0;
      pin = '0;
      preq = '0;
      rst_n = 1'b0;
      iv = $urandom(61);
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      pin <= NUM_GEN'($urandom);
      gap(10);
      rdg(6'h10, 0, gc(0, 0, EN));
      gap(6);
      wr(6'h20, gd(2, 0));
      rd(6'h04, 32'h80, 32'h80);
      gap(2);
      rd(6'h04, 32'h0, 32'h80);
      for (int k = 0; k < 4; k++)
      begin
         wr(6'h20, gd(2, dv[k]));
         wr(6'h10, gc(2, 1, EN | OE | fl[k]));
         rd(6'h04, 32'h80, 32'h80);
         chk("bus_stall_out", 1, stall);
         gap(16);
         chk("pad_oe_out", 1, poe[2]);
         per(2, nn[k]);
      end
      wr(6'h10, gc(2, 5, EN | OE | DU));
      gap(6);
      chk("src_req_out", 6'h22, sreq & 6'h22);
      tog(10, c);
      chk("pad_run", 1, c != 0);
      gap(80);
      chk("src_req_out", 6'h20, sreq & 6'h22);
      wr(6'h10, gc(2, 5, OE));
      gap(8);
      tog(10, c);
      chk("pad_gated", 0, c);
      chk("pad_out", 0, pad[2]);
      wr(6'h10, gc(2, 5, EN | OE | IDL));
      stby <= 1'b1;
      gap(10);
      tog(10, c);
      chk("pad_frozen", 0, c);
      chk("pad_out", 1, pad[2]);
      wr(6'h10, gc(2, 5, EN | OE | IDL | SB));
      gap(10);
      tog(10, c);
      chk("pad_run", 1, c != 0);
      stby <= 1'b0;
      iv = $urandom % 2;
      for (int k = 0; k < 2; k++)
      begin
         wr(6'h10, gc(3, 0, iv * IDL));
         gap(8);
         chk("pad_out", iv, pad[3]);
         chk("pad_oe_out", 0, poe[3]);
         iv = 1 - iv;
      end
      wr(6'h10, gc(3, SRC_PAD, EN | OE));
      gap(8);
      chk("pad_oe_out", 0, poe[3]);
      wr(6'h08, pc(1, 2, 1));
      rd(6'h08, 32'h0, 32'h4000);
      gap(6);
      rd(6'h08, 32'h4000, 32'h4000);
      gap(2);
      tog(1, c);
      chk("pclk_run", 1, c != 0);
      wr(6'h08, pc(1, 2, 0));
      gap(6);
      tog(1, c);
      chk("pclk_gated", 0, c);
      rd(6'h08, 32'h0, 32'h4000);
      wr(6'h10, gc(1, 2, EN));
      gap(6);
      wr(6'h10, gc(1, SRC_PROD1, EN));
      gap(6);
      rdg(6'h10, 1, gc(1, 2, EN));
      wr(6'h10, gc(4, 3, EN));
      wr(6'h20, gd(4, 2));
      gap(8);
      wr(6'h08, pc(3, 4, 3));
      gap(8);
      wr(6'h08, pc(3, 2, 0));
      wr(6'h10, gc(4, 0, 0));
      gap(8);
      wr(6'h08, pc(5, 0, 2));
      gap(8);
      wr(6'h10, gc(0, 1, EN));
      gap(8);
      for (int k = 0; k < 2; k++)
      begin
         rdg(6'h08, 3, pc(3, 4, 3));
         rdg(6'h10, 4, gc(4, 3, EN));
         rdg(6'h20, 4, gd(4, 2));
         rdg(6'h10, 0, gc(0, 1 - k, EN));
         if (k == 0)
         begin
            gap(4);
            wr(6'h00, 32'h1);
            rd(6'h00, 32'h1, 32'h1);
            gap(2);
            rd(6'h00, 32'h0, 32'h1);
            gap(8);
         end
      end
      rdg(6'h10, 2, gc(2, 0, 0));
      rdg(6'h08, 1, pc(1, 0, 0));
      wr(6'h08, pc(6, 5, 0));
      gap(8);
      tog(6, c);
      chk("pclk_stopped", 0, c);
      slp <= 1'b1;
      preq <= NUM_PCLK'($urandom) | 8'h40;
      tog(6, c);
      chk("pclk_woken", 1, c != 0);
      wrap_up();
   end
endmodule
